// ---- hdl/acpd_datapath.sv ----
/*
 * acpd_datapath: accumulator, multiplier, product shifter, input and output
 * shifters and the two status words, all reached as an APB slave.
 * Assumes a single APB master on pclk and that a command word written to the
 * command register stands for one decoded instruction.
 */
`timescale 1ns/100ps

// Overview of operation
// - output shifter shifts accumulator left 0..7
// - upper or lower half goes to bus
// - status zero bit 12 flags overflow
// - clamping loads most positive or negative value
// - status zero bit 11 enables clamping
// - product held in 32-bit register
// - product shifter: none, <<1, <<4, >>6
// - status one bits 1:0 select product shift
// - status one bit 10 sign-extends input shifter
// - same bit picks arithmetic or logical shift
// - sign extension copies value's top bit
// - status one bit 11 holds test outcome
// - status one bit 4 drives flag pin
// - operand register feeds multiply, shifts, tests
// - both status words sixteen bits, saved, restored
// - signed or unsigned 16x16 multiply, 32 bits
// - input shifter shifts left 0..16
module acpd_datapath (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [acpd_pkg::ACPD_AW-1:0] paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	output logic      [15:0]                 write_data_bus,
	output logic                             write_data_strobe,
	output logic                             external_flag_output,
	output logic                             irq
);

	// ************************************************************
	// decode helpers
	// ************************************************************
	// word-aligned address match
	function automatic logic reg_hit(input logic [acpd_pkg::ACPD_AW-1:0] a, input logic [7:0] off);
		reg_hit = (a[acpd_pkg::ACPD_AW-1:2] == off[acpd_pkg::ACPD_AW-1:2]);
	endfunction : reg_hit

	// input shifter: extend then shift left, count limited to 16
	function automatic logic [31:0] in_shift(input logic [15:0] d, input logic [4:0] cnt, input logic sign_extend_enable);
		logic [31:0] ext;
		logic [4:0]  c;
		ext = sign_extend_enable ? {{16{d[15]}}, d} : {16'h0000, d};
		c   = (cnt > acpd_pkg::IN_SHIFT_MAX) ? acpd_pkg::IN_SHIFT_MAX : cnt;
		in_shift = ext << c;
	endfunction : in_shift

	// product shifter
	function automatic logic [31:0] prod_shift(input logic [31:0] p, input logic [1:0] sel);
		unique case (sel)
			2'h0: prod_shift = p;
			2'h1: prod_shift = {p[30:0], 1'b0};
			2'h2: prod_shift = {p[27:0], 4'h0};
			2'h3: prod_shift = {{6{p[31]}}, p[31:6]};
		endcase
	endfunction : prod_shift

	// ************************************************************
	// state
	// ************************************************************
	logic [31:0]            acc_q, acc_d;          // accumulator
	logic [31:0]            multiply_result_reg_q, multiply_result_reg_d;        // multiply_result_reg
	logic [15:0]            multiplier_operand_reg_q;                // multiplier_operand_reg
	logic [15:0]            wdb_q, wdb_d;          // write_data_bus holding register
	logic                   wdb_stb_q;             // store pulse
	logic                   excess_q, excess_d;    // arith_excess_flag
	logic                   clamp_q;               // clamp_enable
	logic [1:0]             psel_q;                // product_shift_select
	logic                   xf_q;                  // external flag latch
	logic                   sxm_q;                 // sign_extend_enable
	logic                   tc_q, tc_d;            // test_result_flag
	logic [acpd_pkg::EV_W-1:0] ev_stat_q, ev_mask_q, ev_set;
	logic [31:0]            rd_q;                  // read data captured in setup
	logic                   err_q;                 // unmapped address in setup

	// ************************************************************
	// command decode
	// ************************************************************
	logic                   wr_acc;                // access-phase write strobe
	logic                   exec;                  // command issued this cycle
	acpd_pkg::acpd_op_type  op;
	logic [15:0]            cmd_data;
	logic [4:0]             cmd_shamt;
	logic [32:0]            sum;                   // sign-extended add/sub result
	logic                   sum_ov;                // overflow of that result
	logic [31:0]            operand_b;             // second addend
	logic                   is_arith;              // op can overflow
	logic                   is_sub;
	logic [31:0]            prod_full;             // raw product
	logic [31:0]            out_shifted;           // output shifter word

	assign wr_acc    = psel && penable && pwrite;
	assign exec      = wr_acc && reg_hit(paddr, acpd_pkg::OFF_COMMAND);
	assign op        = acpd_pkg::acpd_op_type'(pwdata[acpd_pkg::CMD_OP_LO +: 4]);
	assign cmd_data  = pwdata[15:0];
	assign cmd_shamt = pwdata[acpd_pkg::CMD_SHAMT_LO +: 5];

	// multiplier, signed or unsigned by command bit
	always_comb begin
		if (pwdata[acpd_pkg::CMD_UNSIGNED_BIT]) begin
			prod_full = {16'h0000, multiplier_operand_reg_q} * {16'h0000, cmd_data};
		end else begin
			prod_full = 32'($signed(multiplier_operand_reg_q) * $signed(cmd_data));
		end
	end

	// output shifter: accumulator left by 0..7
	assign out_shifted = acc_q << cmd_shamt[2:0];

	// pick the second addend and the direction
	always_comb begin
		operand_b = 32'h00000000;
		is_arith  = 1'b0;
		is_sub    = 1'b0;
		unique case (op)
			acpd_pkg::OP_ADD:  begin
				operand_b = in_shift(cmd_data, cmd_shamt, sxm_q);
				is_arith  = 1'b1;
			end
			acpd_pkg::OP_SUB:  begin
				operand_b = in_shift(cmd_data, cmd_shamt, sxm_q);
				is_arith  = 1'b1;
				is_sub    = 1'b1;
			end
			acpd_pkg::OP_ADDT: begin
				operand_b = in_shift(cmd_data, {1'b0, multiplier_operand_reg_q[3:0]}, sxm_q);
				is_arith  = 1'b1;
			end
			acpd_pkg::OP_SUBT: begin
				operand_b = in_shift(cmd_data, {1'b0, multiplier_operand_reg_q[3:0]}, sxm_q);
				is_arith  = 1'b1;
				is_sub    = 1'b1;
			end
			acpd_pkg::OP_APAC: begin
				operand_b = prod_shift(multiply_result_reg_q, psel_q);
				is_arith  = 1'b1;
			end
			acpd_pkg::OP_SPAC: begin
				operand_b = prod_shift(multiply_result_reg_q, psel_q);
				is_arith  = 1'b1;
				is_sub    = 1'b1;
			end
			default: begin
				operand_b = 32'h00000000;
			end
		endcase
	end

	// 33-bit sum detects leaving the accumulator's range
	assign sum    = is_sub ? ({acc_q[31], acc_q} - {operand_b[31], operand_b})
	                       : ({acc_q[31], acc_q} + {operand_b[31], operand_b});
	assign sum_ov = exec && is_arith && (sum[32] != sum[31]);

	// next values of the datapath registers
	always_comb begin
		acc_d    = acc_q;
		multiply_result_reg_d   = multiply_result_reg_q;
		wdb_d    = wdb_q;
		tc_d     = tc_q;
		excess_d = excess_q;
		if (exec) begin
			unique case (op)
				acpd_pkg::OP_LOAD:  acc_d = in_shift(cmd_data, cmd_shamt, sxm_q);
				acpd_pkg::OP_LOADT: acc_d = in_shift(cmd_data, {1'b0, multiplier_operand_reg_q[3:0]}, sxm_q);
				acpd_pkg::OP_MPY:   multiply_result_reg_d = prod_full;
				acpd_pkg::OP_PAC:   acc_d = prod_shift(multiply_result_reg_q, psel_q);
				acpd_pkg::OP_STORE: begin
					// upper or lower half of the shifted word
					wdb_d = pwdata[acpd_pkg::CMD_HIGH_BIT] ? out_shifted[31:16] : out_shifted[15:0];
				end
				acpd_pkg::OP_SHR: begin
					// arithmetic keeps the sign, logical inserts zero
					acc_d = {sxm_q & acc_q[31], acc_q[31:1]};
				end
				acpd_pkg::OP_BITT: tc_d = cmd_data[multiplier_operand_reg_q[3:0]];
				acpd_pkg::OP_ADD, acpd_pkg::OP_SUB, acpd_pkg::OP_ADDT, acpd_pkg::OP_SUBT,
				acpd_pkg::OP_APAC, acpd_pkg::OP_SPAC: begin
					if (sum_ov && clamp_q) begin
						// clamp toward the direction of the overflow
						acc_d = sum[32] ? acpd_pkg::ACC_MOST_NEG : acpd_pkg::ACC_MOST_POS;
					end else begin
						acc_d = sum[31:0];
					end
				end
				acpd_pkg::OP_NOP: acc_d = acc_q;
				default: acc_d = acc_q;                                     // illegal opcodes ignored
			endcase
		end
		// status word restore by software, overflow set wins over it
		if (wr_acc && reg_hit(paddr, acpd_pkg::OFF_STATUS_ZERO)) begin
			excess_d = pwdata[acpd_pkg::ST0_EXCESS_BIT];
		end
		if (sum_ov) begin
			excess_d = 1'b1;
		end
		if (wr_acc && reg_hit(paddr, acpd_pkg::OFF_STATUS_ONE)) begin
			tc_d = pwdata[acpd_pkg::ST1_TC_BIT];
		end
		if (wr_acc && reg_hit(paddr, acpd_pkg::OFF_ACCUM)) begin
			acc_d = pwdata;
		end
	end

	// ************************************************************
	// datapath registers
	// ************************************************************
	// accumulator, product, write bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q     <= 32'h00000000;
			multiply_result_reg_q    <= 32'h00000000;
			wdb_q     <= 16'h0000;
			wdb_stb_q <= 1'b0;
		end else begin
			acc_q     <= acc_d;
			multiply_result_reg_q    <= multiply_result_reg_d;
			wdb_q     <= wdb_d;
			wdb_stb_q <= exec && (op == acpd_pkg::OP_STORE);
		end
	end

	// operand register, software loaded
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			multiplier_operand_reg_q <= 16'h0000;
		end else if (wr_acc && reg_hit(paddr, acpd_pkg::OFF_OPERAND)) begin
			multiplier_operand_reg_q <= pwdata[15:0];
		end
	end

	// status words
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			excess_q <= 1'b0;
			clamp_q  <= acpd_pkg::RST_CLAMP;
			psel_q   <= acpd_pkg::RST_PSEL;
			xf_q     <= acpd_pkg::RST_XF;
			sxm_q    <= acpd_pkg::RST_SXM;
			tc_q     <= 1'b0;
		end else begin
			excess_q <= excess_d;
			tc_q     <= tc_d;
			if (wr_acc && reg_hit(paddr, acpd_pkg::OFF_STATUS_ZERO)) begin
				clamp_q <= pwdata[acpd_pkg::ST0_CLAMP_BIT];
			end
			if (wr_acc && reg_hit(paddr, acpd_pkg::OFF_STATUS_ONE)) begin
				psel_q <= pwdata[acpd_pkg::ST1_PSEL_LO +: 2];
				xf_q   <= pwdata[acpd_pkg::ST1_XF_BIT];
				sxm_q  <= pwdata[acpd_pkg::ST1_SXM_BIT];
			end
		end
	end

	// ************************************************************
	// interrupts
	// ************************************************************
	assign ev_set[acpd_pkg::EV_EXCESS] = sum_ov;
	assign ev_set[acpd_pkg::EV_STORE]  = exec && (op == acpd_pkg::OP_STORE);
	assign ev_set[acpd_pkg::EV_TEST]   = exec && (op == acpd_pkg::OP_BITT) && tc_d;

	// sticky status, write one clears, a new event wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_stat_q <= '0;
			ev_mask_q <= '0;
		end else begin
			if (wr_acc && reg_hit(paddr, acpd_pkg::OFF_IRQ_STATUS)) begin
				ev_stat_q <= (ev_stat_q & ~pwdata[acpd_pkg::EV_W-1:0]) | ev_set;
			end else begin
				ev_stat_q <= ev_stat_q | ev_set;
			end
			if (wr_acc && reg_hit(paddr, acpd_pkg::OFF_IRQ_MASK)) begin
				ev_mask_q <= pwdata[acpd_pkg::EV_W-1:0];
			end
		end
	end

	// ************************************************************
	// apb read path
	// ************************************************************
	// read data captured in the setup cycle, shown in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_q  <= 32'h00000000;
			err_q <= 1'b0;
		end else if (psel && !penable) begin
			err_q <= 1'b0;
			rd_q  <= 32'h00000000;
			if (reg_hit(paddr, acpd_pkg::OFF_STATUS_ZERO)) begin
				rd_q[acpd_pkg::ST0_EXCESS_BIT] <= excess_q;
				rd_q[acpd_pkg::ST0_CLAMP_BIT]  <= clamp_q;
			end else if (reg_hit(paddr, acpd_pkg::OFF_STATUS_ONE)) begin
				rd_q[acpd_pkg::ST1_PSEL_LO +: 2] <= psel_q;
				rd_q[acpd_pkg::ST1_XF_BIT]       <= external_flag_output;
				rd_q[acpd_pkg::ST1_SXM_BIT]      <= sxm_q;
				rd_q[acpd_pkg::ST1_TC_BIT]       <= tc_q;
			end else if (reg_hit(paddr, acpd_pkg::OFF_OPERAND)) begin
				rd_q[15:0] <= multiplier_operand_reg_q;
			end else if (reg_hit(paddr, acpd_pkg::OFF_PRODUCT)) begin
				rd_q <= multiply_result_reg_q;
			end else if (reg_hit(paddr, acpd_pkg::OFF_ACCUM)) begin
				rd_q <= acc_q;
			end else if (reg_hit(paddr, acpd_pkg::OFF_WRITE_DATA)) begin
				rd_q[15:0] <= wdb_q;
			end else if (reg_hit(paddr, acpd_pkg::OFF_IRQ_STATUS)) begin
				rd_q[acpd_pkg::EV_W-1:0] <= ev_stat_q;
			end else if (reg_hit(paddr, acpd_pkg::OFF_IRQ_MASK)) begin
				rd_q[acpd_pkg::EV_W-1:0] <= ev_mask_q;
			end else if (!reg_hit(paddr, acpd_pkg::OFF_COMMAND)) begin
				err_q <= 1'b1;                                          // unmapped
			end
		end
	end

	assign pready               = 1'b1;
	assign prdata               = rd_q;
	assign pslverr              = err_q && psel && penable;
	assign write_data_bus       = wdb_q;
	assign write_data_strobe    = wdb_stb_q;
	assign external_flag_output = xf_q;
	assign irq                  = |(ev_stat_q & ev_mask_q);

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_excess_flag_set: assert property (sum_ov |=> excess_q && ev_stat_q[acpd_pkg::EV_EXCESS])
		else $error("overflow did not set the excess flag");
	a_clamp_direction: assert property (sum_ov && clamp_q |=> (acc_q == ($past(sum[32]) ?
		acpd_pkg::ACC_MOST_NEG : acpd_pkg::ACC_MOST_POS)))
		else $error("clamped accumulator has the wrong limit");
	a_wrap_no_clamp: assert property (sum_ov && !clamp_q |=> acc_q == $past(sum[31:0]) && excess_q)
		else $error("unclamped overflow did not wrap");
	a_clamp_enable_bit: assert property (wr_acc && reg_hit(paddr, acpd_pkg::OFF_STATUS_ZERO)
		|=> clamp_q == $past(pwdata[acpd_pkg::ST0_CLAMP_BIT]))
		else $error("clamp enable not loaded");
	a_store_half: assert property (exec && op == acpd_pkg::OP_STORE |=> write_data_strobe &&
		write_data_bus == ($past(pwdata[acpd_pkg::CMD_HIGH_BIT]) ? $past(out_shifted[31:16])
		: $past(out_shifted[15:0])))
		else $error("wrong half on the write bus");
	a_out_shift_seven: assert property (exec && op == acpd_pkg::OP_STORE && cmd_shamt[2:0] == 3'h7
		&& !pwdata[acpd_pkg::CMD_HIGH_BIT] |=> write_data_bus[6:0] == 7'h00)
		else $error("output shift by seven left low bits set");
	a_pac_right_six: assert property (exec && op == acpd_pkg::OP_PAC && psel_q == 2'h3
		|=> acc_q == {{6{$past(multiply_result_reg_q[31])}}, $past(multiply_result_reg_q[31:6])})
		else $error("product right shift by six wrong");
	a_mpy_product: assert property (exec && op == acpd_pkg::OP_MPY |=> multiply_result_reg_q ==
		($past(pwdata[acpd_pkg::CMD_UNSIGNED_BIT]) ? {16'h0000, $past(multiplier_operand_reg_q)} * {16'h0000, $past(cmd_data)}
		: 32'($signed($past(multiplier_operand_reg_q)) * $signed($past(cmd_data)))))
		else $error("product register not loaded");
	a_sign_extend_load: assert property (exec && op == acpd_pkg::OP_LOAD && cmd_shamt == 5'h00
		&& cmd_data[15] |=> acc_q[31:16] == {16{$past(sxm_q)}})
		else $error("input shifter extension wrong");
	a_shr_mode: assert property (exec && op == acpd_pkg::OP_SHR |=> acc_q[31] ==
		($past(sxm_q) & $past(acc_q[31])) && acc_q[30:0] == $past(acc_q[31:1]))
		else $error("accumulator right shift mode wrong");
	a_bit_test: assert property (exec && op == acpd_pkg::OP_BITT |=> tc_q == $past(cmd_data[multiplier_operand_reg_q[3:0]]))
		else $error("bit test result not captured");
	a_flag_readback: assert property (psel && !penable && reg_hit(paddr, acpd_pkg::OFF_STATUS_ONE)
		|=> prdata[acpd_pkg::ST1_XF_BIT] == external_flag_output)
		else $error("flag bit read does not match pin");

	c_clamp_pos: cover property (sum_ov && clamp_q && !sum[32]);
	c_clamp_neg: cover property (sum_ov && clamp_q && sum[32]);
	c_store_high: cover property (exec && op == acpd_pkg::OP_STORE && pwdata[acpd_pkg::CMD_HIGH_BIT]);
	c_irq_raised: cover property (!irq ##1 irq);

endmodule : acpd_datapath

// ---- hdl/acpd_pkg.sv ----
/*
 * acpd_pkg: constants for the accumulator and product datapath.
 * Holds register offsets, status bit positions, reset values, saturation
 * limits and the command opcode type. Assumes a 32-bit APB register bus.
 */
package acpd_pkg;

	// ************************************************************
	// bus geometry
	// ************************************************************
	localparam int          ACPD_AW          = 8;        // apb address width
	localparam logic [7:0]  OFF_STATUS_ZERO  = 8'h00;    // status word zero
	localparam logic [7:0]  OFF_STATUS_ONE   = 8'h04;    // status word one
	localparam logic [7:0]  OFF_OPERAND      = 8'h08;    // multiplier operand register
	localparam logic [7:0]  OFF_PRODUCT      = 8'h0C;    // multiply result register
	localparam logic [7:0]  OFF_ACCUM        = 8'h10;    // accumulator
	localparam logic [7:0]  OFF_COMMAND      = 8'h14;    // command register, write only
	localparam logic [7:0]  OFF_WRITE_DATA   = 8'h18;    // last word put on the write bus
	localparam logic [7:0]  OFF_IRQ_STATUS   = 8'h1C;    // sticky events, write one to clear
	localparam logic [7:0]  OFF_IRQ_MASK     = 8'h20;    // event enables

	// ************************************************************
	// status word field positions
	// ************************************************************
	localparam int          ST0_EXCESS_BIT   = 12;       // arith_excess_flag
	localparam int          ST0_CLAMP_BIT    = 11;       // clamp_enable
	localparam int          ST1_PSEL_LO      = 0;        // product_shift_select low bit
	localparam int          ST1_XF_BIT       = 4;        // external flag
	localparam int          ST1_SXM_BIT      = 10;       // sign_extend_enable
	localparam int          ST1_TC_BIT       = 11;       // test_result_flag

	// ************************************************************
	// command word field positions
	// ************************************************************
	localparam int          CMD_SHAMT_LO     = 16;       // 5-bit static shift count
	localparam int          CMD_OP_LO        = 24;       // 4-bit opcode
	localparam int          CMD_HIGH_BIT     = 28;       // store upper half when set
	localparam int          CMD_UNSIGNED_BIT = 29;       // unsigned multiply when set
	localparam logic [4:0]  IN_SHIFT_MAX     = 5'h10;    // input shifter limit, 16

	// ************************************************************
	// event bits
	// ************************************************************
	localparam int          EV_EXCESS        = 0;        // accumulator overflow
	localparam int          EV_STORE         = 1;        // word written to bus
	localparam int          EV_TEST          = 2;        // bit test came out true
	localparam int          EV_W             = 3;        // number of events

	// ************************************************************
	// reset values and limits
	// ************************************************************
	localparam logic        RST_CLAMP        = 1'b0;
	localparam logic        RST_SXM          = 1'b1;
	localparam logic        RST_XF           = 1'b1;
	localparam logic [1:0]  RST_PSEL         = 2'h0;
	localparam logic [31:0] ACC_MOST_POS     = 32'h7FFFFFFF;
	localparam logic [31:0] ACC_MOST_NEG     = 32'h80000000;

	// command opcodes, values 14 and 15 are illegal and ignored
	typedef enum logic [3:0] {
		OP_NOP, OP_LOAD, OP_ADD, OP_SUB, OP_LOADT, OP_ADDT, OP_SUBT, OP_MPY,
		OP_APAC, OP_SPAC, OP_PAC, OP_STORE, OP_SHR, OP_BITT
	} acpd_op_type;

endpackage : acpd_pkg

// ---- bench/acpd_bus_sink.sv ----
/* acpd_bus_sink: far side of the internal write data bus.
 * Assumes one strobe pulse per stored word, sampled on pclk. */
`timescale 1ns/100ps
module acpd_bus_sink (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [15:0] write_data_bus,
	input  wire logic        write_data_strobe,
	output logic      [15:0] seen_word,
	output int               seen_count
);
	// *****
	// capture
	// *****
	// latch each strobed word, as the memory behind the bus would
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_word  <= 16'h0000;
			seen_count <= 0;
		end else if (write_data_strobe) begin
			seen_word  <= write_data_bus;
			seen_count <= seen_count + 1;
		end
	end
endmodule : acpd_bus_sink

// ---- bench/acpd_datapath_tb.sv ----
/* acpd_datapath_tb: APB driven bench with a behavioural model.
 * Assumes zero wait state slave and the bus sink on the write bus. */
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; $display("wrong value t=%0t %h %h", $time, a, b); end end
module acpd_datapath_tb;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000, prdata, rd, acc, prod, e;
	logic        pready, pslverr, strobe, flag, irq;
	logic [15:0] wdb, seen, a, b;
	logic [32:0] r;
	int          seen_n, failures = 0, compares = 0, cyc = 0, sh;
	always #4 pclk = ~pclk;
	acpd_datapath acpd_datapath_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.write_data_bus(wdb), .write_data_strobe(strobe), .external_flag_output(flag), .irq(irq));
	acpd_bus_sink acpd_bus_sink_inst (.pclk(pclk), .presetn(presetn), .write_data_bus(wdb),
		.write_data_strobe(strobe), .seen_word(seen), .seen_count(seen_n));
	// *****
	// bus and model helpers
	// *****
	// one apb transfer; read data taken at the pready edge
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	// command word: unsigned, upper half, opcode, shift, data
	function automatic logic [31:0] cw(input logic [3:0] op, input int s, input logic [15:0] d, input logic hi, us);
		return {2'h0, us, hi, op, 3'h0, 5'(s), d};
	endfunction : cw
	// product shifter model
	function automatic logic [31:0] psh(input logic [31:0] p, input int m);
		return m == 1 ? p << 1 : m == 2 ? p << 4 : m == 3 ? 32'($signed(p) >>> 6) : p;
	endfunction : psh
	task automatic conclude();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : conclude
	// hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			conclude();
		end
	end
	// *****
	// tests
	// *****
	initial begin
		void'($urandom(32'hB0EB8A02));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, acpd_pkg::OFF_STATUS_ONE, 0);
		`CHK(rd, 32'h00000410)
		`CHK(flag, 1'b1)
		apb(1, acpd_pkg::OFF_STATUS_ONE, 32'h00000400);
		apb(0, acpd_pkg::OFF_STATUS_ONE, 0);
		`CHK({flag, rd[4]}, 2'b00)
		$display("test reset done");
		// every product shift mode, mode 2 unsigned
		for (int m = 0; m < 4; m++) begin
			a = 16'($urandom);
			b = 16'($urandom);
			prod = m == 2 ? a * b : 32'($signed(a) * $signed(b));
			apb(1, acpd_pkg::OFF_STATUS_ONE, 32'h00000410 | m);
			apb(1, acpd_pkg::OFF_OPERAND, {16'h0, a});
			apb(1, acpd_pkg::OFF_COMMAND, cw(acpd_pkg::OP_MPY, 0, b, 0, m == 2));
			apb(1, acpd_pkg::OFF_COMMAND, cw(acpd_pkg::OP_PAC, 0, 0, 0, 0));
			apb(0, acpd_pkg::OFF_PRODUCT, 0);
			`CHK(rd, prod)
			apb(0, acpd_pkg::OFF_ACCUM, 0);
			`CHK(rd, psh(prod, m))
		end
		$display("test product done");
		// input shifter and accumulator shift, both extension modes
		for (int x = 0; x < 2; x++) begin
			a = 16'($urandom) | 16'h8000;
			sh = $urandom % 17;
			apb(1, acpd_pkg::OFF_STATUS_ONE, x << 10);
			apb(1, acpd_pkg::OFF_COMMAND, cw(acpd_pkg::OP_LOAD, sh, a, 0, 0));
			apb(0, acpd_pkg::OFF_ACCUM, 0);
			`CHK(rd, (x ? {16'hFFFF, a} : {16'h0, a}) << sh)
			apb(1, acpd_pkg::OFF_ACCUM, 32'h80000010);
			apb(1, acpd_pkg::OFF_COMMAND, cw(acpd_pkg::OP_SHR, 0, 0, 0, 0));
			apb(0, acpd_pkg::OFF_ACCUM, 0);
			`CHK(rd, x ? 32'hC0000008 : 32'h40000008)
		end
		$display("test shifter done");
		// overflow: wrap, clamp high, clamp low
		apb(1, acpd_pkg::OFF_IRQ_MASK, 32'h00000007);
		for (int i = 0; i < 3; i++) begin
			acc = i == 2 ? acpd_pkg::ACC_MOST_NEG : acpd_pkg::ACC_MOST_POS;
			e = i == 0 ? acpd_pkg::ACC_MOST_NEG : acc;
			apb(1, acpd_pkg::OFF_STATUS_ZERO, (i > 0) << 11);
			apb(1, acpd_pkg::OFF_ACCUM, acc);
			apb(1, acpd_pkg::OFF_COMMAND, cw(i == 2 ? acpd_pkg::OP_SUB : acpd_pkg::OP_ADD, 0, 1, 0, 0));
			apb(0, acpd_pkg::OFF_ACCUM, 0);
			`CHK(rd, e)
			apb(0, acpd_pkg::OFF_STATUS_ZERO, 0);
			`CHK(rd, 32'h1000 | ((i > 0) << 11))
			`CHK(irq, 1'b1)
			apb(1, acpd_pkg::OFF_IRQ_STATUS, 32'h00000001);
			@(negedge pclk);
			`CHK(irq, 1'b0)
		end
		$display("test overflow done");
		// every output shift, random half
		for (int s = 0; s < 8; s++) begin
			acc = $urandom;
			r[0] = $urandom % 2;
			e = acc << s;
			apb(1, acpd_pkg::OFF_ACCUM, acc);
			apb(1, acpd_pkg::OFF_COMMAND, cw(acpd_pkg::OP_STORE, s, 0, r[0], 0));
			apb(0, acpd_pkg::OFF_WRITE_DATA, 0);
			`CHK(seen, r[0] ? e[31:16] : e[15:0])
			`CHK(rd[15:0], seen)
			`CHK(seen_n, s + 1)
		end
		$display("test store done");
		// bit test through the operand register, then unmapped read
		apb(1, acpd_pkg::OFF_OPERAND, 32'h00000005);
		apb(1, acpd_pkg::OFF_COMMAND, cw(acpd_pkg::OP_BITT, 0, 16'h0020, 0, 0));
		apb(0, acpd_pkg::OFF_STATUS_ONE, 0);
		`CHK(rd[11], 1'b1)
		apb(0, acpd_pkg::OFF_IRQ_STATUS, 0);
		`CHK(rd[2:1], 2'b11)
		apb(0, 8'hFC, 0);
		`CHK({err, rd}, {1'b1, 32'h0})
		$display("test misc done");
		// dynamic shift from the operand register, product accumulate, no clamping
		sh = $urandom % 16;
		a = 16'($urandom);
		acc = {16'h0, a} << sh;
		apb(1, acpd_pkg::OFF_STATUS_ONE, 32'h00000001);
		apb(1, acpd_pkg::OFF_STATUS_ZERO, 0);
		apb(1, acpd_pkg::OFF_OPERAND, sh);
		apb(1, acpd_pkg::OFF_COMMAND, cw(acpd_pkg::OP_LOADT, 0, a, 0, 0));
		apb(0, acpd_pkg::OFF_ACCUM, 0);
		`CHK(rd, acc)
		apb(1, acpd_pkg::OFF_COMMAND, cw(acpd_pkg::OP_ADDT, 0, a, 0, 0));
		apb(0, acpd_pkg::OFF_ACCUM, 0);
		`CHK(rd, acc + acc)
		apb(1, acpd_pkg::OFF_COMMAND, cw(acpd_pkg::OP_SUBT, 0, a, 0, 0));
		apb(1, acpd_pkg::OFF_COMMAND, cw(acpd_pkg::OP_APAC, 0, 0, 0, 0));
		apb(0, acpd_pkg::OFF_ACCUM, 0);
		`CHK(rd, acc + (prod << 1))
		apb(1, acpd_pkg::OFF_COMMAND, cw(acpd_pkg::OP_SPAC, 0, 0, 0, 0));
		apb(1, acpd_pkg::OFF_COMMAND, cw(acpd_pkg::OP_NOP, 0, 0, 0, 0));
		apb(0, acpd_pkg::OFF_ACCUM, 0);
		`CHK(rd, acc)
		$display("test dynamic done");
		conclude();
	end
endmodule : acpd_datapath_tb
